// [rtl/amp_ctrl_pkg.sv]
// Package for the volume, auto-mute and program control register group.
// Assumes a 250 MHz system clock and a 96 kHz processing sample rate.
package amp_ctrl_pkg;

  // Register offsets on the serial control port.
  localparam logic [7:0] PROG_SELECT_ADDR     = 8'h2B;
  localparam logic [7:0] CLK_ABSENT_ADDR      = 8'h2C;
  localparam logic [7:0] AUTO_MUTE_TIME_ADDR  = 8'h3B;
  localparam logic [7:0] VOL_LINK_ADDR        = 8'h3C;
  localparam logic [7:0] LEFT_VOLUME_ADDR     = 8'h3D;
  localparam logic [7:0] RIGHT_VOLUME_ADDR    = 8'h3E;

  // Field positions.
  localparam int PROG_LSB        = 0;
  localparam int PROG_W          = 5;
  localparam int ABSENT_LSB      = 0;
  localparam int LEFT_LIMIT_LSB  = 4;
  localparam int RIGHT_LIMIT_LSB = 0;
  localparam int LIMIT_W         = 3;
  localparam int LINK_LSB        = 0;
  localparam int LINK_W          = 2;

  // Reset values.
  localparam logic [4:0] PROG_RST   = 5'h01;
  localparam logic [2:0] ABSENT_RST = 3'h0;
  localparam logic [2:0] LIMIT_RST  = 3'h0;
  localparam logic [1:0] LINK_RST   = 2'h0;
  localparam logic [7:0] VOL_RST    = 8'h30;

  // Volume code meanings.
  localparam logic [7:0] VOL_MUTE_CODE = 8'hFF;
  localparam logic [8:0] VOL_TOP_HALF_DB = 9'h030;
  localparam logic [1:0] LINK_INDEPENDENT = 2'h0;
  localparam logic [1:0] LINK_FOLLOW_LEFT = 2'h1;

  // Clock absence timing: one period unit is one second.
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int ABSENT_UNIT_MS  = 1000;
  localparam int ABSENT_UNIT_CYC =
    ABSENT_UNIT_MS * (1_000_000_000 / CLK_PERIOD_PS);
  localparam int PRESCALE_W      = 28;

  // Zero-run lengths in microseconds at the reference sample rate.
  localparam int SAMPLE_RATE_HZ = 96000;
  localparam int ZERO_RUN_US [8] = '{11500, 53000, 106500, 266500,
                                     535000, 1065000, 2665000, 5330000};
  localparam int ZERO_RUN_W     = 19;
  localparam int SAMPLE_W       = 24;

  // Zero-run length in samples for a 3-bit limit code.
  function automatic logic [ZERO_RUN_W-1:0] zero_run_samples(
    input logic [2:0] code
  );
    return ZERO_RUN_W'(ZERO_RUN_US[code] / 1000 * (SAMPLE_RATE_HZ / 1000)
                       + ZERO_RUN_US[code] % 1000 * (SAMPLE_RATE_HZ / 1000)
                       / 1000);
  endfunction

  // One register access from the serial control port.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // One stereo sample pair.
  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } audio_s;

  // Decoded channel gain: signed half-decibel steps plus mute.
  typedef struct packed {
    logic              mute;
    logic signed [8:0] half_db;
  } gain_s;

endpackage

// [rtl/zero_run_mute.sv]
// Consecutive-zero-sample counter that raises auto-mute for one channel.
// Assumes sample_valid pulses once per sample on the system clock.
module zero_run_mute
  import amp_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Sample stream.
  input  wire logic       sample_valid,
  input  wire logic       sample_zero,
  input  wire logic [2:0] limit_code,
  // Result.
  output logic            muted
);

  typedef struct packed {
    logic [ZERO_RUN_W-1:0] count;
    logic                  muted;
  } state_s;

  state_s state_q;
  state_s state_d;

  // Count samples, not time, so the hold scales with the sample rate.
  always_comb begin
    state_d = state_q;
    if (sample_valid) begin
      if (!sample_zero) begin
        // R11 nonzero restarts, releases
        state_d.count = '0;
        state_d.muted = 1'b0;
      end else if (state_q.count + 1'b1 >= zero_run_samples(limit_code)) begin
        // R6 fixed sample count
        state_d.muted = 1'b1;
        state_d.count = zero_run_samples(limit_code);
      end else begin
        state_d.count = state_q.count + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign muted = state_q.muted;

endmodule // zero_run_mute

// [rtl/volume_automute_program_regs.sv]
// Control registers for program select, clock absence, auto-mute and volume.
// Assumes the serial control port decoder delivers one-cycle byte accesses,
// and that the audio bit and frame clocks arrive asynchronously on pins.
//
// Summary of operation
// R1: Five-bit program select, reset code 00001.
// R2: Host avoids reserved program codes.
// R3: Both clocks low n+1 seconds: power down.
// R4: Left mute after chosen zero-sample run.
// R5: Right has own zero-run limit code.
// R6: Limits are sample counts, scale with rate.
// R7: Link 00 independent, 01 right follows left.
// R8: Left code +24 dB, -0.5 dB steps, FF mute.
// R9: Right code same scale, reset 0 dB.
// R10: Only both-low is absence; ignore bit overrides.
// R11: Nonzero sample restarts count, releases mute.
module volume_automute_program_regs
  import amp_ctrl_pkg::*;
#(
  parameter int ABSENT_UNIT_CYCLES = ABSENT_UNIT_CYC
)(
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Serial control port, register side.
  input  amp_ctrl_pkg::reg_req_s      reg_req,
  output logic [7:0]                  reg_rdata,
  // Audio clock pins and clock error control.
  input  wire logic                   bit_clk_pin,
  input  wire logic                   frame_clk_pin,
  input  wire logic                   ignore_clock_absence,
  // Sample stream.
  input  wire logic                   sample_valid,
  input  amp_ctrl_pkg::audio_s        sample,
  // Processing controls.
  output logic [4:0]                  program_sel,
  output amp_ctrl_pkg::gain_s         left_gain,
  output amp_ctrl_pkg::gain_s         right_gain,
  output logic [1:0]                  auto_muted,
  output logic                        clocks_missing,
  output logic                        dac_powerdown
);

  // All state but the zero-run counters in g_mute lives in one record; the comb block fills the next copy.
  typedef struct packed {
    logic [4:0]            prog;
    logic [2:0]            clock_absent_period;
    logic [2:0]            left_zero_run_limit;
    logic [2:0]            right_zero_run_limit;
    logic [1:0]            volume_link_mode;
    logic [7:0]            left_gain_code;
    logic [7:0]            right_gain_code;
    logic [7:0]            rdata;
    logic                  bclk_meta;
    logic                  bclk_sync;
    logic                  fclk_meta;
    logic                  fclk_sync;
    logic [PRESCALE_W-1:0] prescale;
    logic [3:0]            seconds;
    logic                  missing;
    gain_s                 left_gain;
    gain_s                 right_gain;
  } state_s;

  state_s     state_q;
  state_s     state_d;
  logic [7:0] rd_mux;
  logic [7:0] eff_right_code;
  logic [1:0] ch_zero;
  logic [2:0] ch_limit [2];

  // Decode a volume code into half-decibel gain; the top code is mute.
  // Nine signed bits hold every result, from +48 down to -207.
  function automatic gain_s decode_gain(input logic [7:0] code);
    gain_s g;
    g.mute    = (code == VOL_MUTE_CODE);
    g.half_db = $signed(VOL_TOP_HALF_DB) - $signed({1'b0, code});
    return g;
  endfunction

  // Readback mux; unmapped offsets and reserved bits read as zero.
  // The address is decoded at the strobe edge, with no extra stage.
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_req.addr)
      PROG_SELECT_ADDR:
        rd_mux[PROG_LSB +: PROG_W] = state_q.prog;
      CLK_ABSENT_ADDR:
        rd_mux[ABSENT_LSB +: LIMIT_W] = state_q.clock_absent_period;
      AUTO_MUTE_TIME_ADDR: begin
        rd_mux[LEFT_LIMIT_LSB +: LIMIT_W]  = state_q.left_zero_run_limit;
        rd_mux[RIGHT_LIMIT_LSB +: LIMIT_W] = state_q.right_zero_run_limit;
      end
      VOL_LINK_ADDR:
        rd_mux[LINK_LSB +: LINK_W] = state_q.volume_link_mode;
      LEFT_VOLUME_ADDR:  rd_mux = state_q.left_gain_code;
      RIGHT_VOLUME_ADDR: rd_mux = state_q.right_gain_code;
      default:           rd_mux = 8'h00;
    endcase
  end

  // Linked mode makes the right channel use the left code.
  // Link codes other than follow-left behave as independent.
  always_comb begin
    // R7 volume link
    if (state_q.volume_link_mode == LINK_FOLLOW_LEFT) begin
      eff_right_code = state_q.left_gain_code;
    end else begin
      eff_right_code = state_q.right_gain_code;
    end
  end

  // Next-state logic for registers, clock absence and gain outputs.
  always_comb begin
    state_d = state_q;
    if (reg_req.rd) begin
      state_d.rdata = rd_mux;
    end
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        // R1 program field
        PROG_SELECT_ADDR:
          state_d.prog = reg_req.wdata[PROG_LSB +: PROG_W];
        CLK_ABSENT_ADDR:
          state_d.clock_absent_period =
            reg_req.wdata[ABSENT_LSB +: LIMIT_W];
        AUTO_MUTE_TIME_ADDR: begin
          // R4 left limit
          state_d.left_zero_run_limit =
            reg_req.wdata[LEFT_LIMIT_LSB +: LIMIT_W];
          // R5 right limit
          state_d.right_zero_run_limit =
            reg_req.wdata[RIGHT_LIMIT_LSB +: LIMIT_W];
        end
        VOL_LINK_ADDR:
          state_d.volume_link_mode = reg_req.wdata[LINK_LSB +: LINK_W];
        LEFT_VOLUME_ADDR:  state_d.left_gain_code  = reg_req.wdata;
        RIGHT_VOLUME_ADDR: state_d.right_gain_code = reg_req.wdata;
        default: ;
      endcase
    end

    // Two-stage synchronisers for the pin clocks.
    // The pins are unrelated to clk_sys; only the second stage is read.
    state_d.bclk_meta = bit_clk_pin;
    state_d.bclk_sync = state_q.bclk_meta;
    state_d.fclk_meta = frame_clk_pin;
    state_d.fclk_sync = state_q.fclk_meta;

    // R10 both low only
    if (state_q.bclk_sync || state_q.fclk_sync) begin
      state_d.prescale = '0;
      state_d.seconds  = 4'h0;
      state_d.missing  = 1'b0;
    end else if (!state_q.missing) begin
      // A period lowered below the elapsed seconds count mid-count is met only after seconds wraps.
      // R3 absence timer
      if (state_q.prescale == PRESCALE_W'(ABSENT_UNIT_CYCLES - 1)) begin
        state_d.prescale = '0;
        state_d.seconds  = state_q.seconds + 4'h1;
        if (state_q.seconds == {1'b0, state_q.clock_absent_period}) begin
          state_d.missing = 1'b1;
        end
      end else begin
        state_d.prescale = state_q.prescale + 1'b1;
      end
    end

    // R8 left decode
    state_d.left_gain  = decode_gain(state_q.left_gain_code);
    // R9 right decode
    state_d.right_gain = decode_gain(eff_right_code);
  end

  // State register; gains are preset so 0 dB shows from the first cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q                 <= '0;
      state_q.prog            <= PROG_RST;
      state_q.clock_absent_period  <= ABSENT_RST;
      state_q.left_zero_run_limit  <= LIMIT_RST;
      state_q.right_zero_run_limit <= LIMIT_RST;
      state_q.volume_link_mode     <= LINK_RST;
      state_q.left_gain_code  <= VOL_RST;
      state_q.right_gain_code <= VOL_RST;
      state_q.left_gain       <= decode_gain(VOL_RST);
      state_q.right_gain      <= decode_gain(VOL_RST);
    end else begin
      state_q <= state_d;
    end
  end

  // Per-channel zero detection and limit selection.
  // A sample is zero only when every one of its bits is clear.
  assign ch_zero[0]  = (sample.left == '0);
  assign ch_zero[1]  = (sample.right == '0);
  assign ch_limit[0] = state_q.left_zero_run_limit;
  assign ch_limit[1] = state_q.right_zero_run_limit;

  // One zero-run detector per channel; a reused channel restarts cleanly.
  for (genvar ch = 0; ch < 2; ch++) begin : g_mute
    zero_run_mute u_mute (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .sample_valid (sample_valid),
      .sample_zero  (ch_zero[ch]),
      .limit_code   (ch_limit[ch]),
      .muted        (auto_muted[ch])
    );
  end

  // Outputs. The ignore bit only masks power-down, not the status.
  assign reg_rdata      = state_q.rdata;
  assign program_sel    = state_q.prog;
  assign left_gain      = state_q.left_gain;
  assign right_gain     = state_q.right_gain;
  assign clocks_missing = state_q.missing;
  // Combinational so a newly set ignore bit takes effect at once.
  // R10 ignore overrides
  assign dac_powerdown  = state_q.missing & ~ignore_clock_absence;

endmodule // volume_automute_program_regs

// [tb/host_port_model.sv]
// Host model that drives the register port of the control group.
// Assumes one-cycle strobes and read data one cycle after the read edge.
module host_port_model
  import amp_ctrl_pkg::*;
(
  // Clock.
  input  wire logic              clk_sys,
  // Register port.
  output amp_ctrl_pkg::reg_req_s req,
  input  wire logic [7:0]        rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // One write strobe; the host never offers an unusable program code.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    if (a == PROG_SELECT_ADDR && d[4:0] inside {5'h00, 5'h02, 5'h03})
      return;
    @(posedge clk_sys) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys) #1;
    req.wr = 1'b0;
  endtask

  // One read strobe; data is taken one edge after the strobe is sampled.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys) #1;
    req.rd = 1'b0;
    @(posedge clk_sys) #1;
    d = rdata;
  endtask
endmodule // host_port_model

// [tb/volume_automute_program_regs_chk.sv]
// Checker for the control register group, bound to its top ports.
// Assumes the design package is compiled first.
module volume_automute_program_regs_chk
  import amp_ctrl_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          reset,
  input amp_ctrl_pkg::reg_req_s reg_req,
  input wire logic [7:0]    reg_rdata,
  input wire logic          bit_clk_pin,
  input wire logic          frame_clk_pin,
  input wire logic          ignore_clock_absence,
  input wire logic          sample_valid,
  input amp_ctrl_pkg::audio_s sample,
  input wire logic [4:0]    program_sel,
  input amp_ctrl_pkg::gain_s left_gain,
  input amp_ctrl_pkg::gain_s right_gain,
  input wire logic [1:0]    auto_muted,
  input wire logic          clocks_missing,
  input wire logic          dac_powerdown
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [1:0] link_q;

  // Shadow of the link field, since it is not visible at the ports.
  always_ff @(posedge clk_sys) begin
    if (reset) link_q <= 2'h0;
    else if (reg_req.wr && reg_req.addr == VOL_LINK_ADDR)
      link_q <= reg_req.wdata[1:0];
  end

  property p_pwrdn;
    dac_powerdown == (clocks_missing && !ignore_clock_absence);
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("powerdown mismatch");
  property p_pin_high;
    $rose(bit_clk_pin) |-> ##[1:4] !clocks_missing;
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("missing held");
  property p_rise_low;
    $rose(clocks_missing) |->
      !$past(bit_clk_pin, 4) && !$past(frame_clk_pin, 4);
  endproperty
  a_rise_low: assert property (p_rise_low) else $error("missing early");
  property p_left_vol;
    reg_req.wr && reg_req.addr == LEFT_VOLUME_ADDR &&
      reg_req.wdata != VOL_MUTE_CODE |-> ##2 !left_gain.mute &&
      left_gain.half_db == VOL_TOP_HALF_DB - {1'b0, $past(reg_req.wdata, 2)};
  endproperty
  a_left_vol: assert property (p_left_vol) else $error("left gain");
  property p_left_mute;
    reg_req.wr && reg_req.addr == LEFT_VOLUME_ADDR &&
      reg_req.wdata == VOL_MUTE_CODE |-> ##2 left_gain.mute;
  endproperty
  a_left_mute: assert property (p_left_mute) else $error("left mute");
  property p_link;
    link_q == LINK_FOLLOW_LEFT && $past(link_q) == LINK_FOLLOW_LEFT &&
      $past(link_q, 2) == LINK_FOLLOW_LEFT |-> right_gain == left_gain;
  endproperty
  a_link: assert property (p_link) else $error("right not linked");
  property p_rd_hold;
    !reg_req.rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_prog_rsvd;
    reg_req.rd && reg_req.addr == PROG_SELECT_ADDR |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_prog_rsvd: assert property (p_prog_rsvd) else $error("reserved bits");
  property p_unmute;
    $fell(auto_muted[0]) |->
      $past(sample_valid) && $past(sample.left) != '0;
  endproperty
  a_unmute: assert property (p_unmute) else $error("left unmuted");
endmodule // volume_automute_program_regs_chk

bind volume_automute_program_regs volume_automute_program_regs_chk chk (
  .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .bit_clk_pin(bit_clk_pin),
  .frame_clk_pin(frame_clk_pin),
  .ignore_clock_absence(ignore_clock_absence),
  .sample_valid(sample_valid), .sample(sample), .program_sel(program_sel),
  .left_gain(left_gain), .right_gain(right_gain), .auto_muted(auto_muted),
  .clocks_missing(clocks_missing), .dac_powerdown(dac_powerdown));

// [tb/tb_volume_automute_program_regs.sv]
// Self-checking bench for the control register group.
// Assumes the host model and the checker are compiled beforehand.
module tb_volume_automute_program_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import amp_ctrl_pkg::*;
  typedef struct packed {logic [7:0] a, d, e;} row_s;
  logic clk_sys, reset, bit_clk_pin, frame_clk_pin, ignore_clock_absence;
  logic sample_valid, clocks_missing, dac_powerdown;
  logic [4:0] program_sel;
  logic [1:0] auto_muted;
  logic [7:0] reg_rdata, rd;
  reg_req_s   reg_req;
  audio_s     sample;
  gain_s      left_gain, right_gain;
  int         num_errors = 0, n_tests = 0;
  row_s rst_rows [6] = '{'{8'h2B, 8'h0, 8'h01}, '{8'h2C, 8'h0, 8'h00},
    '{8'h3B, 8'h0, 8'h00}, '{8'h3C, 8'h0, 8'h00}, '{8'h3D, 8'h0, 8'h30},
    '{8'h3E, 8'h0, 8'h30}};
  row_s rows [5] = '{'{8'h2B, 8'hE5, 8'h05}, '{8'h2C, 8'hFF, 8'h07},
    '{8'h3B, 8'hFF, 8'h77}, '{8'h3E, 8'h00, 8'h00}, '{8'h50, 8'hAA, 8'h00}};

  // Short absence unit keeps the one-second counts to a few cycles.
  volume_automute_program_regs #(.ABSENT_UNIT_CYCLES(10)) dut (
    .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .bit_clk_pin(bit_clk_pin),
    .frame_clk_pin(frame_clk_pin),
    .ignore_clock_absence(ignore_clock_absence),
    .sample_valid(sample_valid), .sample(sample), .program_sel(program_sel),
    .left_gain(left_gain), .right_gain(right_gain),
    .auto_muted(auto_muted), .clocks_missing(clocks_missing),
    .dac_powerdown(dac_powerdown));
  host_port_model hm (.clk_sys(clk_sys), .req(reg_req), .rdata(reg_rdata));

  task automatic check(input string nm, input logic [8:0] e, logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Watchdog: the whole run needs well under ten thousand cycles.
  initial begin
    #40000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {reset, bit_clk_pin, frame_clk_pin} = 3'b111;
    {ignore_clock_absence, sample_valid, sample} = '0;
    repeat (10) @(posedge clk_sys);
    #1 reset = 1'b0;
    check("prog", 9'h01, {4'h0, program_sel});
    check("lgain", 9'h000, left_gain.half_db);
    check("lmute0", 9'h000, {8'h00, left_gain.mute});
    foreach (rst_rows[i]) begin
      hm.read_reg(rst_rows[i].a, rd);
      check("reset read", {1'b0, rst_rows[i].e}, {1'b0, rd});
    end
    foreach (rows[i]) begin
      hm.write_reg(rows[i].a, rows[i].d);
      hm.read_reg(rows[i].a, rd);
      check("readback", {1'b0, rows[i].e}, {1'b0, rd});
    end
    check("prog sel", 9'h05, {4'h0, program_sel});
    // Gain decode at both ends of the scale and the mute code.
    foreach (rows[i]) begin
      hm.write_reg(LEFT_VOLUME_ADDR, 8'hFE >> i);
      repeat (2) @(posedge clk_sys);
      #1 check("lvol", 9'(48 - (8'hFE >> i)), left_gain.half_db);
    end
    hm.write_reg(LEFT_VOLUME_ADDR, 8'hFF);
    repeat (2) @(posedge clk_sys);
    #1 check("lmute", 9'h001, {8'h00, left_gain.mute});
    hm.write_reg(RIGHT_VOLUME_ADDR, 8'h10);
    hm.write_reg(LEFT_VOLUME_ADDR, 8'h20);
    repeat (2) @(posedge clk_sys);
    #1 check("rvol", 9'd32, right_gain.half_db);
    hm.write_reg(VOL_LINK_ADDR, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 check("linked", 9'd16, right_gain.half_db);
    hm.write_reg(LEFT_VOLUME_ADDR, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 check("top", 9'd48, left_gain.half_db);
    check("rlinked", 9'd48, right_gain.half_db);
    // Frame low alone is not absence; then both low for two units.
    hm.write_reg(CLK_ABSENT_ADDR, 8'h01);
    frame_clk_pin = 1'b0;
    repeat (40) @(posedge clk_sys);
    #1 check("one low", 9'h000, {8'h00, clocks_missing});
    bit_clk_pin = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 check("early", 9'h000, {8'h00, clocks_missing});
    for (int i = 0; i < 4 && clocks_missing !== 1'b1; i++)
      @(posedge clk_sys) #1;
    check("missing", 9'h003, {7'h00, clocks_missing, dac_powerdown});
    ignore_clock_absence = 1'b1;
    @(posedge clk_sys) #1;
    check("ignored", 9'h000, {8'h00, dac_powerdown});
    check("status", 9'h001, {8'h00, clocks_missing});
    bit_clk_pin = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 check("back", 9'h000, {8'h00, clocks_missing});
    // Shortest zero run, one sample per cycle, then left goes nonzero.
    hm.write_reg(AUTO_MUTE_TIME_ADDR, 8'h00);
    sample_valid = 1'b1;
    repeat (1103) @(posedge clk_sys);
    #1 check("run-1", 9'h000, {7'h00, auto_muted});
    @(posedge clk_sys) #1 check("run", 9'h003, {7'h00, auto_muted});
    sample.left = 24'h000001;
    repeat (2) @(posedge clk_sys);
    #1 check("release", 9'h002, {7'h00, auto_muted});
    sample_valid = 1'b0;
    tally_and_finish();
  end
endmodule // tb_volume_automute_program_regs
